// ===== rtl/tmr_reg_bank.sv
// Thermal monitor register bank: command pointer, values, limits, alarms
// Function
// R1 - Remote signed high bytes at 0x11/0x12: sign then 64..1 degrees, read-only
// R2 - Remote unsigned high bytes at 0x19/0x1A: 128..1 degrees, read-only
// R3 - Signed low bytes: three fractions, two finer bits only when filtering
// R4 - Unsigned low bytes use the same fraction layout, other bits zero
// R5 - First critical limit per remote channel, read/write, resets to 0x6E
// R6 - One shared limit per remote channel drives second and third alarms
// R7 - Diode fault byte: open and short flags per remote, remote two upper
// R8 - Reading a high byte freezes its low byte until that is read
// R9 - One-shot write in standby runs one round; data dropped, reads zero
// R10 - Alarm holds until temperature falls below limit minus hysteresis
// R11 - Faulted remote reads most negative signed, zero unsigned, sets flags
// R12 - Unused bits read zero and ignore writes; channel enable bits 4:3 reset to one and keep reading one
module tmr_reg_bank
  import tmr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter logic [7:0] MAKER_ID = 8'h3c, // Arbitrary value
  parameter logic [7:0] SILICON_REVISION = 8'h42 // Arbitrary value
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_set,
  input wire logic [7:0] cmd_byte,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic conv_start,
  output logic [1:0] conv_chan,
  input wire logic conv_done,
  input wire logic signed [13:0] conv_temp,
  input wire logic conv_open,
  input wire logic conv_short,
  output logic alarm_out_a,
  output logic alarm_out_b,
  output logic alarm_out_c
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] cmd_reg;
  logic [7:0] config_reg;
  logic [7:0] rate_reg;
  logic [7:0] chan_en_reg;
  logic [7:0] filter_reg;
  logic [7:0] mask_a_reg;
  logic [7:0] mask_b_reg;
  logic [7:0] mask_c_reg;
  logic [7:0] corr_reg [2];
  logic [7:0] local_lim_reg;
  logic [7:0] first_lim_reg [2];
  logic [7:0] shared_lim_reg [2];
  logic [7:0] hyst_reg;
  logic signed [12:0] local_reg;
  logic signed [12:0] rs_reg [2];
  logic [12:0] ru_reg [2];
  logic [1:0] open_reg;
  logic [1:0] short_reg;
  logic [2:0] upd_reg;
  logic not_ready_reg;
  logic [7:0] frozen_reg [5];
  logic [4:0] lock_reg;

  logic busy;
  logic round_done;
  logic oneshot;
  logic standby_select;
  logic [4:0] hot;
  logic [2:0] st_a;
  logic [2:0] st_b;
  logic [7:0] live_low [5];
  logic [7:0] rd_value;
  logic [2:0] hi_idx;
  logic [2:0] lo_idx;
  logic signed [14:0] corrected;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [12:0] sat_signed(input logic signed [14:0] v);
    if (v > SIGNED_MAX)
      return SIGNED_MAX[12:0];
    else if (v < $signed(SIGNED_MIN))
      return SIGNED_MIN[12:0];
    else
      return v[12:0];
  endfunction

  function automatic logic [12:0] sat_unsigned(input logic signed [14:0] v);
    if (v < ZERO_15)
      return '0;
    else if (v > UNSIGNED_MAX)
      return UNSIGNED_MAX[12:0];
    else
      return v[12:0];
  endfunction

  // Finer bits shown only while that channel's filter is on
  function automatic logic [7:0] low_byte(input logic [4:0] frac, input logic filt_on);
    return {frac[4:2], (filt_on ? frac[1:0] : 2'b00), 3'b000}; // [R3] [R4] [R12]
  endfunction

  function automatic logic [7:0] wmask(input logic [7:0] old, input logic [7:0] d,
                                       input logic [7:0] m);
    return (old & ~m) | (d & m); // [R12]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command pointer and write port
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_reg <= RST_CMD;
    else if (cmd_set)
      cmd_reg <= cmd_byte;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_reg <= RST_CONFIG;
      rate_reg <= RST_RATE;
      chan_en_reg <= RST_CHAN_EN;
      filter_reg <= RST_FILTER;
      mask_a_reg <= RST_MASK_A;
      mask_b_reg <= RST_MASK_B;
      mask_c_reg <= RST_MASK_C;
      corr_reg[0] <= RST_CORR;
      corr_reg[1] <= RST_CORR;
      local_lim_reg <= RST_LOCAL_LIM;
      first_lim_reg[0] <= RST_FIRST;
      first_lim_reg[1] <= RST_FIRST;
      shared_lim_reg[0] <= RST_SHARED;
      shared_lim_reg[1] <= RST_SHARED;
      hyst_reg <= RST_HYST;
    end
    else if (wr_en)
    begin
      case (cmd_reg)
        CMD_CONFIG: config_reg <= wmask(config_reg, wr_data, WM_CONFIG);
        CMD_RATE: rate_reg <= wmask(rate_reg, wr_data, WM_RATE);
        CMD_CHAN_EN: chan_en_reg <= wmask(chan_en_reg, wr_data, WM_CHAN_EN);
        CMD_FILTER: filter_reg <= wmask(filter_reg, wr_data, WM_FILTER);
        CMD_ALARM_A_MASK: mask_a_reg <= wmask(mask_a_reg, wr_data, WM_MASK);
        CMD_ALARM_B_MASK: mask_b_reg <= wmask(mask_b_reg, wr_data, WM_MASK);
        CMD_ALARM_C_MASK: mask_c_reg <= wmask(mask_c_reg, wr_data, WM_MASK);
        CMD_R1_CORR: corr_reg[0] <= wr_data;
        CMD_R2_CORR: corr_reg[1] <= wr_data;
        CMD_LOCAL_LIM: local_lim_reg <= wmask(local_lim_reg, wr_data, WM_LOCAL_LIM);
        CMD_R1_FIRST: first_lim_reg[0] <= wr_data; // [R5]
        CMD_R2_FIRST: first_lim_reg[1] <= wr_data; // [R5]
        CMD_R1_SHARED: shared_lim_reg[0] <= wr_data; // [R6]
        CMD_R2_SHARED: shared_lim_reg[1] <= wr_data; // [R6]
        CMD_HYST: hyst_reg <= wmask(hyst_reg, wr_data, WM_HYST);
        default: ;
      endcase
    end
  end

  assign standby_select = config_reg[STANDBY_BIT];
  // Write data is never stored; outside standby the write has no effect
  assign oneshot = wr_en && (cmd_reg == CMD_ONESHOT) && standby_select; // [R9]

  ////////////////////////////////////////////////////////////////////////////
  // Conversion scheduling and result capture
  tmr_conv_sched #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_sched (
    .clk(clk),
    .rst_n(rst_n),
    .standby(standby_select),
    .oneshot(oneshot),
    .rate(rate_reg[1:0]),
    .chan_en(chan_en_reg[2:0]),
    .conv_done(conv_done),
    .conv_start(conv_start),
    .conv_chan(conv_chan),
    .busy(busy),
    .round_done(round_done)
  );

  // Correction has a half-degree step; shifted into 1/32 degree units
  assign corrected = $signed({conv_temp[13], conv_temp}) +
                     $signed({{3{corr_reg[conv_chan[1]][7]}}, corr_reg[conv_chan[1]], 4'h0});

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      local_reg <= '0;
      rs_reg[0] <= '0;
      rs_reg[1] <= '0;
      ru_reg[0] <= '0;
      ru_reg[1] <= '0;
      open_reg <= '0;
      short_reg <= '0;
      upd_reg <= '0;
    end
    else
    begin
      upd_reg <= '0;
      if (conv_done && busy)
      begin
        upd_reg[conv_chan] <= 1'b1;
        if (conv_chan == CH_LOCAL)
          local_reg <= sat_signed({conv_temp[13], conv_temp});
        else
        begin
          open_reg[conv_chan[1]] <= conv_open; // [R7]
          short_reg[conv_chan[1]] <= conv_short; // [R7]
          if (conv_open || conv_short)
          begin
            rs_reg[conv_chan[1]] <= SIGNED_MIN[12:0]; // [R11]
            ru_reg[conv_chan[1]] <= '0; // [R11]
          end
          else
          begin
            rs_reg[conv_chan[1]] <= sat_signed(corrected);
            ru_reg[conv_chan[1]] <= sat_unsigned(corrected);
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      not_ready_reg <= 1'b1;
    else if (round_done)
      not_ready_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Critical comparisons: local, remote first limits, remote shared limits
  for (genvar g = 0; g < 5; g++)
  begin : g_cmp
    tmr_crit_cmp u_cmp (
      .clk(clk),
      .rst_n(rst_n),
      .update(g == 0 ? upd_reg[0] : upd_reg[(g + 1) % 2 + 1]),
      .temp(g == 0 ? {local_reg[12], local_reg[12:5]} :
            $signed({1'b0, ru_reg[(g + 1) % 2][12:5]})),
      .limit(g == 0 ? local_lim_reg :
             (g < 3 ? first_lim_reg[(g + 1) % 2] : shared_lim_reg[(g + 1) % 2])), // [R6]
      .hyst(hyst_reg),
      .hot(hot[g])
    );
  end

  assign st_a = {hot[2], hot[1], hot[0]};
  assign st_b = {hot[4], hot[3], hot[0]}; // [R6]

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_out_a <= 1'b0;
      alarm_out_b <= 1'b0;
      alarm_out_c <= 1'b0;
    end
    else
    begin
      alarm_out_a <= |(st_a & ~mask_a_reg[2:0]); // [R10]
      alarm_out_b <= |(st_b & ~mask_b_reg[2:0]);
      alarm_out_c <= |(st_b & ~mask_c_reg[2:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side: live low bytes, freeze on high-byte read
  assign live_low[0] = {local_reg[4:2], 5'b00000}; // [R12]
  assign live_low[1] = low_byte(rs_reg[0][4:0], filter_reg[1:0] != 2'b00); // [R3]
  assign live_low[2] = low_byte(rs_reg[1][4:0], filter_reg[3:2] != 2'b00); // [R3]
  assign live_low[3] = low_byte(ru_reg[0][4:0], filter_reg[1:0] != 2'b00); // [R4]
  assign live_low[4] = low_byte(ru_reg[1][4:0], filter_reg[3:2] != 2'b00); // [R4]

  always_comb
  begin
    hi_idx = 3'h7;
    lo_idx = 3'h7;
    rd_value = 8'h00; // [R12]
    case (cmd_reg)
      CMD_COMMON_STATUS: rd_value = {busy, not_ready_reg, 2'b00, |st_b, |st_b, |st_a,
                                     |{open_reg, short_reg}};
      CMD_CONFIG: rd_value = config_reg;
      CMD_RATE: rd_value = rate_reg;
      CMD_CHAN_EN: rd_value = chan_en_reg;
      CMD_FILTER: rd_value = filter_reg;
      CMD_FAULT: rd_value = {4'h0, open_reg[1], short_reg[1], open_reg[0], short_reg[0]}; // [R7]
      CMD_ALARM_A_ST: rd_value = {5'b00000, st_a};
      CMD_ALARM_B_ST: rd_value = {5'b00000, st_b};
      CMD_ALARM_C_ST: rd_value = {5'b00000, st_b};
      CMD_ALARM_A_MASK: rd_value = mask_a_reg;
      CMD_ALARM_B_MASK: rd_value = mask_b_reg;
      CMD_ALARM_C_MASK: rd_value = mask_c_reg;
      CMD_LOCAL_HI: begin rd_value = local_reg[12:5]; hi_idx = 3'h0; end
      CMD_R1_SHI: begin rd_value = rs_reg[0][12:5]; hi_idx = 3'h1; end // [R1]
      CMD_R2_SHI: begin rd_value = rs_reg[1][12:5]; hi_idx = 3'h2; end // [R1]
      CMD_R1_UHI: begin rd_value = ru_reg[0][12:5]; hi_idx = 3'h3; end // [R2]
      CMD_R2_UHI: begin rd_value = ru_reg[1][12:5]; hi_idx = 3'h4; end // [R2]
      CMD_LOCAL_LO: lo_idx = 3'h0;
      CMD_R1_SLO: lo_idx = 3'h1;
      CMD_R2_SLO: lo_idx = 3'h2;
      CMD_R1_ULO: lo_idx = 3'h3;
      CMD_R2_ULO: lo_idx = 3'h4;
      CMD_R1_CORR: rd_value = corr_reg[0];
      CMD_R2_CORR: rd_value = corr_reg[1];
      CMD_LOCAL_LIM: rd_value = local_lim_reg;
      CMD_R1_FIRST: rd_value = first_lim_reg[0];
      CMD_R2_FIRST: rd_value = first_lim_reg[1];
      CMD_R1_SHARED: rd_value = shared_lim_reg[0];
      CMD_R2_SHARED: rd_value = shared_lim_reg[1];
      CMD_HYST: rd_value = hyst_reg;
      CMD_MAKER: rd_value = MAKER_ID;
      CMD_REVISION: rd_value = SILICON_REVISION;
      default: rd_value = 8'h00; // [R9]
    endcase
    if (lo_idx != 3'h7)
      rd_value = lock_reg[lo_idx] ? frozen_reg[lo_idx] : live_low[lo_idx]; // [R8]
  end

  // A new high-byte read always overrides an older freeze of the same low byte
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_reg <= '0;
      for (int i = 0; i < 5; i++)
        frozen_reg[i] <= '0;
    end
    else if (rd_en && hi_idx != 3'h7)
    begin
      lock_reg[hi_idx] <= 1'b1; // [R8]
      frozen_reg[hi_idx] <= live_low[hi_idx]; // [R8]
    end
    else if (rd_en && lo_idx != 3'h7)
      lock_reg[lo_idx] <= 1'b0; // [R8]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= rd_value;
    end
  end

endmodule

// ===== rtl/tmr_pkg.sv
// Shared constants, register map and types of the thermal monitor register bank
package tmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_COMMON_STATUS = 8'h02;
  localparam logic [7:0] CMD_CONFIG = 8'h03;
  localparam logic [7:0] CMD_RATE = 8'h04;
  localparam logic [7:0] CMD_CHAN_EN = 8'h05;
  localparam logic [7:0] CMD_FILTER = 8'h06;
  localparam logic [7:0] CMD_FAULT = 8'h07;
  localparam logic [7:0] CMD_ALARM_A_ST = 8'h08;
  localparam logic [7:0] CMD_ALARM_B_ST = 8'h09;
  localparam logic [7:0] CMD_ALARM_C_ST = 8'h0a;
  localparam logic [7:0] CMD_ALARM_A_MASK = 8'h0c;
  localparam logic [7:0] CMD_ALARM_B_MASK = 8'h0d;
  localparam logic [7:0] CMD_ALARM_C_MASK = 8'h0e;
  localparam logic [7:0] CMD_ONESHOT = 8'h0f;
  localparam logic [7:0] CMD_LOCAL_HI = 8'h10;
  localparam logic [7:0] CMD_R1_SHI = 8'h11;
  localparam logic [7:0] CMD_R2_SHI = 8'h12;
  localparam logic [7:0] CMD_R1_UHI = 8'h19;
  localparam logic [7:0] CMD_R2_UHI = 8'h1a;
  localparam logic [7:0] CMD_LOCAL_LO = 8'h20;
  localparam logic [7:0] CMD_R1_SLO = 8'h21;
  localparam logic [7:0] CMD_R2_SLO = 8'h22;
  localparam logic [7:0] CMD_R1_ULO = 8'h29;
  localparam logic [7:0] CMD_R2_ULO = 8'h2a;
  localparam logic [7:0] CMD_R1_CORR = 8'h31;
  localparam logic [7:0] CMD_R2_CORR = 8'h32;
  localparam logic [7:0] CMD_LOCAL_LIM = 8'h40;
  localparam logic [7:0] CMD_R1_FIRST = 8'h41;
  localparam logic [7:0] CMD_R2_FIRST = 8'h42;
  localparam logic [7:0] CMD_R1_SHARED = 8'h49;
  localparam logic [7:0] CMD_R2_SHARED = 8'h4a;
  localparam logic [7:0] CMD_HYST = 8'h5a;
  localparam logic [7:0] CMD_MAKER = 8'hfe;
  localparam logic [7:0] CMD_REVISION = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and writable bits
  localparam logic [7:0] RST_CMD = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h02;
  localparam logic [7:0] RST_CHAN_EN = 8'h1f;
  localparam logic [7:0] RST_FILTER = 8'h0f;
  localparam logic [7:0] RST_MASK_A = 8'h01;
  localparam logic [7:0] RST_MASK_B = 8'h00;
  localparam logic [7:0] RST_MASK_C = 8'h07;
  localparam logic [7:0] RST_CORR = 8'h00;
  localparam logic [7:0] RST_LOCAL_LIM = 8'h55;
  localparam logic [7:0] RST_FIRST = 8'h6e;
  localparam logic [7:0] RST_SHARED = 8'h55;
  localparam logic [7:0] RST_HYST = 8'h0a;
  localparam logic [7:0] WM_CONFIG = 8'h40;
  localparam logic [7:0] WM_RATE = 8'h03;
  localparam logic [7:0] WM_CHAN_EN = 8'h07;
  localparam logic [7:0] WM_FILTER = 8'h0f;
  localparam logic [7:0] WM_MASK = 8'h07;
  localparam logic [7:0] WM_LOCAL_LIM = 8'h7f;
  localparam logic [7:0] WM_HYST = 8'h1f;
  localparam int STANDBY_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Channels, temperature format and saturation bounds (1/32 degree units)
  localparam logic [1:0] CH_LOCAL = 2'h0;
  localparam logic [1:0] CH_R1 = 2'h1;
  localparam logic [1:0] CH_R2 = 2'h2;
  localparam logic [1:0] CH_NONE = 2'h3;
  localparam int TEMP_W = 14;
  localparam logic signed [14:0] SIGNED_MAX = 15'sh0fff;
  localparam logic signed [14:0] SIGNED_MIN = 15'sh7000;
  localparam logic signed [14:0] UNSIGNED_MAX = 15'sh1fff;
  localparam logic signed [14:0] ZERO_15 = 15'sh0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 40;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES_DEF = CLK_MHZ * TICK_US;
  localparam logic [11:0] RATE_MS_0 = 12'h000;
  localparam logic [11:0] RATE_MS_1 = 12'h7d0;
  localparam logic [11:0] RATE_MS_2 = 12'h3e8;
  localparam logic [11:0] RATE_MS_3 = 12'h1f4;

  typedef enum logic [1:0] {
    SCH_IDLE = 2'b00,
    SCH_START = 2'b01,
    SCH_WAIT = 2'b11,
    SCH_NEXT = 2'b10
  } tmr_sched_state_t;

endpackage

// ===== rtl/tmr_crit_cmp.sv
// Critical limit comparator with hysteresis, updated once per conversion
module tmr_crit_cmp
  import tmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic update,
  input wire logic signed [8:0] temp,
  input wire logic [7:0] limit,
  input wire logic [7:0] hyst,
  output logic hot
);

  logic signed [9:0] set_lvl;
  logic signed [9:0] clr_lvl;
  logic signed [9:0] temp_x;

  assign temp_x = {temp[8], temp};
  assign set_lvl = $signed({2'b00, limit});
  // Signed so that a hysteresis above the limit does not wrap
  assign clr_lvl = $signed({2'b00, limit}) - $signed({2'b00, hyst});

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hot <= 1'b0;
    else if (update)
    begin
      if (!hot && temp_x > set_lvl)
        hot <= 1'b1;
      else if (hot && temp_x < clr_lvl)
        hot <= 1'b0; // [R10]
    end
  end

endmodule

// ===== rtl/tmr_conv_sched.sv
// Conversion round scheduler: rate timer, standby and single rounds
module tmr_conv_sched
  import tmr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic standby,
  input wire logic oneshot,
  input wire logic [1:0] rate,
  input wire logic [2:0] chan_en,
  input wire logic conv_done,
  output logic conv_start,
  output logic [1:0] conv_chan,
  output logic busy,
  output logic round_done
);

  tmr_sched_state_t state_reg;
  logic [31:0] tick_cnt_reg;
  logic [11:0] ms_cnt_reg;
  logic [11:0] period;
  logic oneshot_pend_reg;
  logic start_round;
  logic [1:0] pick;

  function automatic logic [1:0] next_chan(input logic [2:0] en, input logic [1:0] from);
    logic [1:0] r;
    r = CH_NONE;
    for (int i = 2; i >= 0; i--)
      if (en[i] && 2'(i) >= from)
        r = 2'(i);
    return r;
  endfunction

  always_comb
  begin
    case (rate)
      2'h0: period = RATE_MS_0;
      2'h1: period = RATE_MS_1;
      2'h2: period = RATE_MS_2;
      default: period = RATE_MS_3;
    endcase
  end

  assign start_round = (state_reg == SCH_IDLE) &&
                       (standby ? oneshot_pend_reg : (ms_cnt_reg >= period)); // [R9]
  assign pick = (state_reg == SCH_IDLE) ? next_chan(chan_en, CH_LOCAL) :
                next_chan(chan_en, conv_chan + 2'h1);
  assign conv_start = (state_reg == SCH_START);
  assign busy = (state_reg != SCH_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt_reg <= '0;
    else if (tick_cnt_reg == 32'(TICK_CYCLES - 1))
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ms_cnt_reg <= '0;
    else if (start_round)
      ms_cnt_reg <= '0;
    else if (tick_cnt_reg == 32'(TICK_CYCLES - 1) && ms_cnt_reg != 12'hfff)
      ms_cnt_reg <= ms_cnt_reg + 12'h1;
  end

  // A write landing in the cycle a round starts is kept for the next round
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oneshot_pend_reg <= 1'b0;
    else if (oneshot)
      oneshot_pend_reg <= 1'b1; // [R9]
    else if (start_round)
      oneshot_pend_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= SCH_IDLE;
      conv_chan <= CH_LOCAL;
      round_done <= 1'b0;
    end
    else
    begin
      round_done <= 1'b0;
      case (state_reg)
        SCH_IDLE:
          if (start_round)
          begin
            if (pick == CH_NONE)
              round_done <= 1'b1;
            else
            begin
              conv_chan <= pick;
              state_reg <= SCH_START;
            end
          end
        SCH_START:
          state_reg <= SCH_WAIT;
        SCH_WAIT:
          if (conv_done)
            state_reg <= SCH_NEXT;
        SCH_NEXT:
          if (conv_chan == CH_R2 || pick == CH_NONE)
          begin
            round_done <= 1'b1;
            state_reg <= SCH_IDLE;
          end
          else
          begin
            conv_chan <= pick;
            state_reg <= SCH_START;
          end
        default:
          state_reg <= SCH_IDLE;
      endcase
    end
  end

endmodule

// ===== verif/tmr_reg_bank_monitor.sv
// Checker of read answers, padding bits and alarm timing
module tmr_reg_bank_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_set,
  input wire logic [7:0] cmd_byte,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic conv_done,
  input wire logic alarm_out_a,
  input wire logic alarm_out_b
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ptr_reg;
  logic [3:0] ev_reg;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Shadow pointer and recent events; alarms move only a few edges after one
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ptr_reg <= 8'h00;
    else if (cmd_set)
      ptr_reg <= cmd_byte;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ev_reg <= 4'h0;
    else
      ev_reg <= {ev_reg[2:0], conv_done | wr_en};
  ////////////////////////////////////////
  property p_answer;
    rd_en |=> rd_valid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("read not answered");
  property p_hold;
    $changed(rd_data) |-> rd_valid;
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved without a read");
  property p_oneshot;
    rd_valid && $past(ptr_reg) == 8'h0f |-> rd_data == 8'h00;
  endproperty
  a_oneshot: assert property (p_oneshot)
    else $error("trigger location not zero");
  property p_fault;
    rd_valid && $past(ptr_reg) == 8'h07 |-> rd_data[7:4] == 4'h0;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault byte upper bits set");
  property p_rlow;
    rd_valid && $past(ptr_reg) inside {8'h21, 8'h22, 8'h29, 8'h2a} |-> rd_data[2:0] == 3'h0;
  endproperty
  a_rlow: assert property (p_rlow)
    else $error("remote low padding set");
  property p_llow;
    rd_valid && $past(ptr_reg) == 8'h20 |-> rd_data[4:0] == 5'h00;
  endproperty
  a_llow: assert property (p_llow)
    else $error("local low padding set");
  property p_alarm_a;
    $changed(alarm_out_a) |-> ev_reg != 4'h0;
  endproperty
  a_alarm_a: assert property (p_alarm_a)
    else $error("alarm a moved without cause");
  property p_alarm_b;
    $changed(alarm_out_b) |-> ev_reg != 4'h0;
  endproperty
  a_alarm_b: assert property (p_alarm_b)
    else $error("alarm b moved without cause");
endmodule

bind tmr_reg_bank tmr_reg_bank_monitor u_mon (.clk(clk), .rst_n(rst_n), .cmd_set(cmd_set),
  .cmd_byte(cmd_byte), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
  .conv_done(conv_done), .alarm_out_a(alarm_out_a), .alarm_out_b(alarm_out_b));

// ===== verif/tmr_conv_model.sv
// Behavioural converter answering each measurement request
module tmr_conv_model (
  input wire logic clk,
  input wire logic conv_start,
  input wire logic [1:0] conv_chan,
  input wire logic signed [13:0] t_local,
  input wire logic signed [13:0] t_one,
  input wire logic signed [13:0] t_two,
  input wire logic open_two,
  output logic conv_done,
  output logic signed [13:0] conv_temp,
  output logic conv_open,
  output logic conv_short
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    conv_done = 1'b0;
    conv_temp = 14'sh0000;
    conv_open = 1'b0;
    conv_short = 1'b0;
    forever
    begin
      @(negedge clk);
      if (conv_start === 1'b1)
      begin
        // Remote diodes answer after six clocks, the local one after one
        repeat (conv_chan == 2'h0 ? 1 : 6) @(posedge clk);
        conv_done <= 1'b1;
        conv_temp <= conv_chan == 2'h1 ? t_one : (conv_chan == 2'h2 ? t_two : t_local);
        conv_open <= conv_chan == 2'h2 && open_two;
        conv_short <= 1'b0;
        @(posedge clk);
        conv_done <= 1'b0;
        // Result no longer held: show the inverse so stale sampling is caught
        conv_temp <= ~conv_temp;
        conv_open <= ~conv_open;
        conv_short <= 1'b1;
      end
    end
  end
endmodule

// ===== verif/test_tmr_reg_bank.sv
// Self-checking bench of the thermal monitor register bank
module test_tmr_reg_bank;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_set = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic open_two = 1'b1;
  logic [7:0] cmd_byte = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_data;
  logic rd_valid, conv_start, conv_done, conv_open, conv_short;
  logic alarm_out_a, alarm_out_b, alarm_out_c;
  logic [1:0] conv_chan;
  logic signed [13:0] conv_temp;
  logic signed [13:0] t_local = 14'sh0320;
  logic signed [13:0] t_one = 14'sh0c91;
  logic signed [13:0] t_two = 14'sh0100;
  int err_count = 0;
  int check_count = 0;
  // Command byte then expected value
  logic [15:0] rst_tab [16] = '{16'h0300, 16'h0402, 16'h051f, 16'h060f, 16'h0c01, 16'h0d00,
    16'h0e07, 16'h0f00, 16'h3100, 16'h4055, 16'h416e, 16'h426e, 16'h4955, 16'h4a55,
    16'h5a0a, 16'hfe3c};
  logic [15:0] run_tab [15] = '{16'h1019, 16'h2000, 16'h1164, 16'h2188, 16'h1964, 16'h2988,
    16'h1280, 16'h2200, 16'h1a00, 16'h2a00, 16'h0708, 16'h0802, 16'h0902, 16'h0a02, 16'h020f};
  tmr_reg_bank #(.TICK_CYCLES(20)) DUT (.clk(clk), .rst_n(rst_n), .cmd_set(cmd_set),
    .cmd_byte(cmd_byte), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
    .rd_valid(rd_valid), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_done(conv_done), .conv_temp(conv_temp), .conv_open(conv_open),
    .conv_short(conv_short), .alarm_out_a(alarm_out_a), .alarm_out_b(alarm_out_b),
    .alarm_out_c(alarm_out_c));
  tmr_conv_model u_conv (.clk(clk), .conv_start(conv_start), .conv_chan(conv_chan),
    .t_local(t_local), .t_one(t_one), .t_two(t_two), .open_two(open_two),
    .conv_done(conv_done), .conv_temp(conv_temp), .conv_open(conv_open),
    .conv_short(conv_short));
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic point(input logic [7:0] c);
    @(posedge clk);
    cmd_set <= 1'b1;
    cmd_byte <= c;
    @(posedge clk);
    cmd_set <= 1'b0;
  endtask
  task automatic put(input logic [7:0] c, input logic [7:0] d);
    point(c);
    wr_en <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic get(input logic [7:0] c, input logic [7:0] e);
    point(c);
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_valid === 1'b1 ? rd_data : ~e, e);
  endtask
  // One triggered round; all three channels must answer within the bound
  task automatic round();
    int n;
    int k;
    put(8'h0f, 8'ha5);
    n = 0;
    k = 0;
    while (k < 3 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
      k += int'(conv_done === 1'b1);
    end
    if (k < 3)
    begin
      err_count++;
      wrap_up();
    end
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rst_tab[i]) get(rst_tab[i][15:8], rst_tab[i][7:0]);
    $display("reset values done");
    put(8'h5a, 8'hff);
    get(8'h5a, 8'h1f);
    put(8'h41, 8'h63);
    get(8'h41, 8'h63);
    put(8'h11, 8'h55);
    put(8'h03, 8'h40);
    get(8'h03, 8'h40);
    $display("writes done");
    round();
    foreach (run_tab[i]) get(run_tab[i][15:8], run_tab[i][7:0]);
    chk({5'h00, alarm_out_a, alarm_out_b, alarm_out_c}, 8'h06);
    $display("first round done");
    open_two <= 1'b0;
    t_one <= 14'sh0be0;
    t_two <= 14'sh0c80;
    put(8'h0e, 8'h03);
    round();
    get(8'h07, 8'h00);
    get(8'h09, 8'h06);
    get(8'h11, 8'h5f);
    chk({5'h00, alarm_out_a, alarm_out_b, alarm_out_c}, 8'h07);
    put(8'h06, 8'h00);
    t_one <= 14'sh0649;
    round();
    get(8'h21, 8'h00);
    get(8'h21, 8'h40);
    get(8'h29, 8'h40);
    chk({5'h00, alarm_out_a, alarm_out_b, alarm_out_c}, 8'h03);
    $display("hysteresis and freeze done");
    wrap_up();
  end
endmodule
